// ==== verilog/stl_pkg.sv ====
package stl_pkg;

  // ************************************************************
  // Self-test select bit positions
  // ************************************************************
  localparam int DRV_LOGIC_SUPPLY_BIT = 7;
  localparam int DRV_HIGH_SHORT_BIT = 6;
  localparam int DRV_LOW_SHORT_BIT = 5;
  localparam int DRV_HIGH_DS_BIT = 2;
  localparam int DRV_LOW_DS_BIT = 1;
  localparam logic [7:0] DRV_VALID_MASK = 8'he6;
  localparam logic [7:0] AMP_VALID_MASK = 8'h7f;
  localparam int AMP_SUPPLY_BIT = 0;
  localparam logic [7:0] SELECT_RESET = 8'h00;

  // ************************************************************
  // Battery supply thresholds, in units of 10 mV
  // ************************************************************
  localparam int VOLT_W = 16;
  localparam logic [3:0] OV_LEVEL_RESET = 4'h0;
  localparam logic [3:0] UV_LEVEL_RESET = 4'h7;
  localparam logic [3:0] OV_LEVEL_LAST = 4'h7;
  localparam logic [15:0] OV_TABLE [0:7] = '{16'h0708, 16'h07dd, 16'h0969, 16'h0af5,
                                              16'h0c82, 16'h0d57, 16'h0e0e, 16'h0f9b};
  localparam logic [15:0] UV_TABLE [0:15] = '{16'h01e8, 16'h0206, 16'h0225, 16'h0243,
                                               16'h0262, 16'h0280, 16'h029f, 16'h02bd,
                                               16'h02dc, 16'h02fa, 16'h0319, 16'h0337,
                                               16'h0356, 16'h0374, 16'h0393, 16'h03b1};
  localparam logic [15:0] OV_SHUTDOWN_DEFAULT = 16'h1194;

  // ************************************************************
  // Filter times and error reactions
  // ************************************************************
  localparam logic [1:0] OV_FILTER_RESET = 2'h0;
  localparam logic [1:0] UV_FILTER_RESET = 2'h1;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FILTER_10US_NS = 10000;
  localparam int FILTER_25US_NS = 25000;
  localparam int FILTER_50US_NS = 50000;
  localparam int FILTER_100US_NS = 100000;
  localparam int CNT_W = 16;
  localparam int SHUTDOWN_ERR_OV_BIT = 6;
  localparam int EXT_ERR_UV_BIT = 3;
  localparam int EXT_ERR_OV_BIT = 2;

  typedef enum logic [1:0] {
    STL_REACT_WARN = 2'b00,
    STL_REACT_ERR = 2'b01,
    STL_REACT_AUTO = 2'b10,
    STL_REACT_LATCH = 2'b11
  } stl_react_t;

endpackage : stl_pkg

// ==== verilog/stl_supervisor.sv ====
`timescale 1ns/1ps
module stl_supervisor #(
  parameter int FILT0_CYC = (stl_pkg::FILTER_10US_NS + stl_pkg::CLK_PERIOD_NS - 1) / stl_pkg::CLK_PERIOD_NS,
  parameter int FILT1_CYC = (stl_pkg::FILTER_25US_NS + stl_pkg::CLK_PERIOD_NS - 1) / stl_pkg::CLK_PERIOD_NS,
  parameter int FILT2_CYC = (stl_pkg::FILTER_50US_NS + stl_pkg::CLK_PERIOD_NS - 1) / stl_pkg::CLK_PERIOD_NS,
  parameter int FILT3_CYC = (stl_pkg::FILTER_100US_NS + stl_pkg::CLK_PERIOD_NS - 1) / stl_pkg::CLK_PERIOD_NS,
  parameter logic [15:0] OV_SHUTDOWN_LEVEL = stl_pkg::OV_SHUTDOWN_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Self-test select registers
  input wire logic selftest_mode,
  input wire logic select_driver_wr,
  input wire logic [7:0] select_driver_wdata,
  input wire logic select_amplifier_wr,
  input wire logic [7:0] select_amplifier_wdata,
  output logic [7:0] selftest_select_driver,
  output logic [7:0] selftest_select_amplifier,
  // Active test strobes
  output logic test_logic_supply_check,
  output logic test_high_short_detector,
  output logic test_low_short_detector,
  output logic measure_high_drain_source,
  output logic measure_low_drain_source,
  output logic [5:0] amp_gain_test,
  output logic amp_supply_test,
  // Stage enables
  output logic output_stage_enable,
  output logic charge_pump_enable,
  output logic [2:0] current_sense_amplifier_enable,
  // Limp-home
  input wire logic limp_mode,
  input wire logic [2:0] limp_bridge,
  input wire logic [2:0] low_side_control_input,
  input wire logic [2:0] high_side_control_input_n,
  output logic [2:0] low_side_gated,
  output logic [2:0] high_side_gated_n,
  output logic [2:0] failure_register_enable,
  output logic short_detect_enable,
  output logic bootstrap_uv_enable,
  output logic feedback_enable,
  output logic limp_reaction_active,
  // Battery supervision configuration
  input wire logic [3:0] battery_overvoltage_level,
  input wire logic [3:0] battery_undervoltage_level,
  input wire logic [1:0] battery_overvoltage_filter,
  input wire logic [1:0] battery_undervoltage_filter,
  input wire logic [1:0] battery_ov_reaction,
  input wire logic [1:0] battery_uv_reaction,
  input wire logic ov_shutdown_enable,
  // Battery measurement and errors
  input wire logic sample_valid,
  input wire logic [15:0] battery_sample,
  input wire logic error_clear,
  output logic [15:0] battery_voltage_result,
  output logic [7:0] shutdown_error_register,
  output logic [7:0] external_error_register,
  output logic battery_error_flag,
  output logic battery_warning_flag,
  output logic battery_fets_off
);

  // ************************************************************
  // Self-test selection
  // ************************************************************
  logic [7:0] drv_r, drv_nxt, amp_r, amp_nxt;
  logic [4:0] drv_act_r, drv_act_nxt;
  logic [6:0] amp_act_r, amp_act_nxt;
  logic [2:0] csa_en_r, csa_en_nxt;

  always_comb begin
    drv_nxt = drv_r;
    amp_nxt = amp_r;
    // Reserved positions are masked off so they never act and read zero.
    if (select_driver_wr) begin
      drv_nxt = select_driver_wdata & stl_pkg::DRV_VALID_MASK;
    end
    if (select_amplifier_wr) begin
      amp_nxt = select_amplifier_wdata & stl_pkg::AMP_VALID_MASK;
    end
    drv_act_nxt = 5'h00;
    amp_act_nxt = 7'h00;
    // Highest-priority bit wins so a careless multi-bit write still runs one test.
    if (selftest_mode) begin
      if (drv_r[stl_pkg::DRV_LOGIC_SUPPLY_BIT]) drv_act_nxt = 5'h10;
      else if (drv_r[stl_pkg::DRV_HIGH_SHORT_BIT]) drv_act_nxt = 5'h08;
      else if (drv_r[stl_pkg::DRV_LOW_SHORT_BIT]) drv_act_nxt = 5'h04;
      else if (drv_r[stl_pkg::DRV_HIGH_DS_BIT]) drv_act_nxt = 5'h02;
      else if (drv_r[stl_pkg::DRV_LOW_DS_BIT]) drv_act_nxt = 5'h01;
      for (int i = 6; i >= 0; i--) begin
        if (amp_r[i] && amp_act_nxt == 7'h00) begin
          amp_act_nxt = 7'(1 << i);
        end
      end
    end
    // Gain tests on bits 6..1 map pairwise to amplifiers 3,2,1.
    csa_en_nxt = ~{|amp_act_nxt[6:5], |amp_act_nxt[4:3], |amp_act_nxt[2:1]};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_r <= stl_pkg::SELECT_RESET;
      amp_r <= stl_pkg::SELECT_RESET;
      drv_act_r <= 5'h00;
      amp_act_r <= 7'h00;
      csa_en_r <= 3'h7;
    end else begin
      drv_r <= drv_nxt;
      amp_r <= amp_nxt;
      drv_act_r <= drv_act_nxt;
      amp_act_r <= amp_act_nxt;
      csa_en_r <= csa_en_nxt;
    end
  end

  assign selftest_select_driver = drv_r;
  assign selftest_select_amplifier = amp_r;
  assign {test_logic_supply_check, test_high_short_detector, test_low_short_detector,
          measure_high_drain_source, measure_low_drain_source} = drv_act_r;
  assign amp_gain_test = amp_act_r[6:1];
  assign amp_supply_test = amp_act_r[stl_pkg::AMP_SUPPLY_BIT];
  assign current_sense_amplifier_enable = csa_en_r;

  // ************************************************************
  // Limp-home masking
  // ************************************************************
  logic [2:0] ls_r, ls_nxt, hs_n_r, hs_n_nxt, fr_en_r, fr_en_nxt;
  logic limp_r, limp_nxt;

  always_comb begin
    limp_nxt = limp_mode;
    // Only the host-chosen bridge is masked; a bridge is parked low-side off, high-side off.
    fr_en_nxt = limp_mode ? ~limp_bridge : 3'h7;
    ls_nxt = low_side_control_input & fr_en_nxt;
    hs_n_nxt = high_side_control_input_n | ~fr_en_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      limp_r <= 1'b0;
      fr_en_r <= 3'h7;
      ls_r <= 3'h0;
      hs_n_r <= 3'h7;
    end else begin
      limp_r <= limp_nxt;
      fr_en_r <= fr_en_nxt;
      ls_r <= ls_nxt;
      hs_n_r <= hs_n_nxt;
    end
  end

  assign low_side_gated = ls_r;
  assign high_side_gated_n = hs_n_r;
  assign failure_register_enable = fr_en_r;
  assign short_detect_enable = ~limp_r;
  assign bootstrap_uv_enable = ~limp_r;
  assign feedback_enable = ~limp_r;
  assign limp_reaction_active = limp_r;

  // ************************************************************
  // Battery supply supervision
  // ************************************************************
  logic [15:0] result_r, result_nxt;
  logic [2:0] cond;
  logic [1:0] fsel [0:2];
  logic [2:0] flt_r;
  logic uv_r, uv_nxt, ov_r, ov_nxt, sd_r, sd_nxt;
  logic err_r, err_nxt, warn_r, warn_nxt, off_r, off_nxt, lat_r, lat_nxt;

  function automatic logic [15:0] filt_cycles(input logic [1:0] code);
    case (code)
      2'h0: filt_cycles = 16'(FILT0_CYC);
      2'h1: filt_cycles = 16'(FILT1_CYC);
      2'h2: filt_cycles = 16'(FILT2_CYC);
      default: filt_cycles = 16'(FILT3_CYC);
    endcase
  endfunction : filt_cycles

  // Reserved overvoltage codes keep the highest valid level, the safe side.
  always_comb begin
    result_nxt = sample_valid ? battery_sample : result_r;
    cond[0] = result_r < stl_pkg::UV_TABLE[battery_undervoltage_level];
    cond[1] = result_r > stl_pkg::OV_TABLE[(battery_overvoltage_level > stl_pkg::OV_LEVEL_LAST) ?
              3'h7 : battery_overvoltage_level[2:0]];
    cond[2] = ov_shutdown_enable && result_r > OV_SHUTDOWN_LEVEL;
    fsel[0] = battery_undervoltage_filter;
    fsel[1] = battery_overvoltage_filter;
    fsel[2] = battery_overvoltage_filter;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      logic [15:0] cnt_r, cnt_nxt;
      logic hit_nxt;
      always_comb begin
        cnt_nxt = 16'h0000;
        if (cond[g]) begin
          cnt_nxt = (cnt_r >= filt_cycles(fsel[g])) ? cnt_r : cnt_r + 16'h0001;
        end
        hit_nxt = cond[g] && (cnt_nxt >= filt_cycles(fsel[g]));
      end
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt_r <= 16'h0000;
          flt_r[g] <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          flt_r[g] <= hit_nxt;
        end
      end
    end
  endgenerate

  // Sticky flags: a new detection in the clear cycle wins over the clear.
  always_comb begin
    uv_nxt = flt_r[0] | (uv_r & ~error_clear);
    ov_nxt = flt_r[1] | (ov_r & ~error_clear);
    sd_nxt = flt_r[2] | (sd_r & ~error_clear);
    lat_nxt = lat_r & ~error_clear;
    warn_nxt = 1'b0;
    err_nxt = 1'b0;
    off_nxt = 1'b0;
    case (stl_pkg::stl_react_t'(battery_uv_reaction))
      stl_pkg::STL_REACT_WARN: warn_nxt = uv_nxt;
      stl_pkg::STL_REACT_ERR: err_nxt = uv_nxt;
      stl_pkg::STL_REACT_AUTO: off_nxt = flt_r[0];
      stl_pkg::STL_REACT_LATCH: lat_nxt = lat_nxt | flt_r[0];
      default: warn_nxt = uv_nxt;
    endcase
    case (stl_pkg::stl_react_t'(battery_ov_reaction))
      stl_pkg::STL_REACT_WARN: warn_nxt = warn_nxt | ov_nxt;
      stl_pkg::STL_REACT_ERR: err_nxt = err_nxt | ov_nxt;
      stl_pkg::STL_REACT_AUTO: off_nxt = off_nxt | flt_r[1];
      stl_pkg::STL_REACT_LATCH: lat_nxt = lat_nxt | flt_r[1];
      default: warn_nxt = warn_nxt | ov_nxt;
    endcase
    // Shutdown is always a latched error.
    lat_nxt = lat_nxt | flt_r[2];
    off_nxt = off_nxt | lat_nxt;
    err_nxt = err_nxt | off_nxt | sd_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= 16'h0000;
      uv_r <= 1'b0;
      ov_r <= 1'b0;
      sd_r <= 1'b0;
      lat_r <= 1'b0;
      warn_r <= 1'b0;
      err_r <= 1'b0;
      off_r <= 1'b0;
    end else begin
      result_r <= result_nxt;
      uv_r <= uv_nxt;
      ov_r <= ov_nxt;
      sd_r <= sd_nxt;
      lat_r <= lat_nxt;
      warn_r <= warn_nxt;
      err_r <= err_nxt;
      off_r <= off_nxt;
    end
  end

  assign battery_voltage_result = result_r;
  assign shutdown_error_register = 8'(sd_r) << stl_pkg::SHUTDOWN_ERR_OV_BIT;
  assign external_error_register = (8'(uv_r) << stl_pkg::EXT_ERR_UV_BIT) |
                                   (8'(ov_r) << stl_pkg::EXT_ERR_OV_BIT);
  assign battery_warning_flag = warn_r;
  assign battery_error_flag = err_r;
  assign battery_fets_off = off_r;
  // Self-tests never switch stages or pumps off; only a supply fault does.
  assign output_stage_enable = ~off_r;
  assign charge_pump_enable = ~sd_r;

endmodule : stl_supervisor

// ==== tb/stl_supervisor_asserts.sv ====
`timescale 1ns/1ps
module stl_supervisor_checker #(
  parameter int FILT0_CYC = 5,
  parameter int FILT1_CYC = 10,
  parameter int FILT2_CYC = 20,
  parameter int FILT3_CYC = 40
) (
  // Clock, reset and stimulus
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic selftest_mode,
  input wire logic select_driver_wr,
  input wire logic [7:0] select_driver_wdata,
  input wire logic limp_mode,
  input wire logic [2:0] limp_bridge,
  input wire logic [3:0] battery_undervoltage_level,
  input wire logic [1:0] battery_undervoltage_filter,
  input wire logic sample_valid,
  input wire logic [15:0] battery_sample,
  // Responses
  input wire logic [7:0] selftest_select_driver,
  input wire logic test_logic_supply_check,
  input wire logic test_high_short_detector,
  input wire logic test_low_short_detector,
  input wire logic measure_high_drain_source,
  input wire logic measure_low_drain_source,
  input wire logic [5:0] amp_gain_test,
  input wire logic [2:0] current_sense_amplifier_enable,
  input wire logic [2:0] low_side_gated,
  input wire logic [2:0] failure_register_enable,
  input wire logic [15:0] battery_voltage_result,
  input wire logic [7:0] external_error_register,
  input wire logic [7:0] shutdown_error_register
);
  localparam int FILT_CYC [0:3] = '{FILT0_CYC, FILT1_CYC, FILT2_CYC, FILT3_CYC};
  logic [4:0] drv_tests;
  logic [15:0] uv_run_r, uv_run_nxt;
  assign drv_tests = {test_logic_supply_check, test_high_short_detector, test_low_short_detector,
                      measure_high_drain_source, measure_low_drain_source};
  // The run length saturates, so a long undervoltage never wraps below a filter count.
  always_comb begin
    uv_run_nxt = (battery_voltage_result < stl_pkg::UV_TABLE[battery_undervoltage_level]) ?
                 uv_run_r + {15'h0000, ~&uv_run_r} : 16'h0000;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) uv_run_r <= 16'h0000;
    else uv_run_r <= uv_run_nxt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // Assertions
  // ************************************************************
  AST_DRV_READBACK: assert property (select_driver_wr |=> selftest_select_driver ==
    ($past(select_driver_wdata) & stl_pkg::DRV_VALID_MASK)) else $error("driver select readback wrong");
  AST_NO_TEST_OUT_OF_MODE: assert property ((!selftest_mode) [*2] |-> {drv_tests, amp_gain_test} == 11'h000)
    else $error("self-test active outside self-test mode");
  AST_GAIN_AMP3_OFF: assert property ((|amp_gain_test[5:4]) [*2] |-> current_sense_amplifier_enable == 3'h3)
    else $error("gain test did not switch off only its amplifier");
  AST_DRV_AMPS_ON: assert property ((drv_tests != 5'h00 && amp_gain_test == 6'h00) [*2] |->
    current_sense_amplifier_enable == 3'h7) else $error("amplifier off during driver test");
  AST_LIMP_MASK: assert property (limp_mode |=> failure_register_enable == ~$past(limp_bridge) &&
    (low_side_gated & $past(limp_bridge)) == 3'h0) else $error("limp bridge not masked");
  AST_RESULT: assert property (sample_valid |=> battery_voltage_result == $past(battery_sample))
    else $error("result register not loaded");
  AST_ERR_BITS: assert property ((external_error_register & 8'hf3) == 8'h00 &&
    (shutdown_error_register & 8'hbf) == 8'h00) else $error("unexpected error bit set");
  AST_UV_FILTER: assert property ($rose(external_error_register[3]) |->
    uv_run_r >= 16'(FILT_CYC[battery_undervoltage_filter])) else $error("undervoltage flag before filter time");
  COV_DRV_TEST: cover property (test_logic_supply_check);
  COV_LIMP: cover property (limp_mode ##1 limp_mode);
  COV_UV_SET: cover property ($rose(external_error_register[3]));
endmodule : stl_supervisor_checker
bind stl_supervisor stl_supervisor_checker #(.FILT0_CYC(FILT0_CYC), .FILT1_CYC(FILT1_CYC), .FILT2_CYC(FILT2_CYC),
  .FILT3_CYC(FILT3_CYC)) i_checker (.*);

// ==== tb/stl_host_model.sv ====
`timescale 1ns/1ps
module stl_host_model (
  // Requests driven into the supervisor
  input wire logic sys_clk,
  output logic selftest_mode,
  output logic select_driver_wr,
  output logic [7:0] select_driver_wdata,
  output logic select_amplifier_wr,
  output logic [7:0] select_amplifier_wdata,
  output logic limp_mode,
  output logic [2:0] limp_bridge,
  output logic sample_valid,
  output logic [15:0] battery_sample,
  output logic error_clear
);
  // ************************************************************
  // Host sequences
  // ************************************************************
  initial begin
    {selftest_mode, select_driver_wr, select_amplifier_wr, limp_mode, sample_valid, error_clear} = '0;
    {select_driver_wdata, select_amplifier_wdata, limp_bridge, battery_sample} = '0;
  end
  task automatic set_lvl(input logic m, input logic lm, input int bi);
    @(posedge sys_clk);
    #1;
    selftest_mode = m;
    limp_mode = lm;
    limp_bridge = 3'h1 << bi;
  endtask : set_lvl
  // The idle data bus carries the inverse, so a wrong register pick never sees a plausible value.
  task automatic write_sel(input logic amp, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    {select_driver_wr, select_amplifier_wr} = {!amp, amp};
    {select_driver_wdata, select_amplifier_wdata} = amp ? {~d, d} : {d, ~d};
    @(posedge sys_clk);
    #1;
    {select_driver_wr, select_amplifier_wr} = 2'h0;
    {select_driver_wdata, select_amplifier_wdata} = {~d, ~d};
  endtask : write_sel
  task automatic pulse(input logic smp, input logic [15:0] v);
    @(posedge sys_clk);
    #1;
    {sample_valid, error_clear} = {smp, !smp};
    battery_sample = v;
    @(posedge sys_clk);
    #1;
    {sample_valid, error_clear} = 2'h0;
    battery_sample = ~v;
  endtask : pulse
endmodule : stl_host_model

// ==== tb/test_stl_supervisor.sv ====
`timescale 1ns/1ps
module test_stl_supervisor;
  localparam int F [0:3] = '{5, 10, 20, 40};
  logic sys_clk, rst_n, selftest_mode, select_driver_wr, select_amplifier_wr, sample_valid, error_clear, limp_mode;
  logic test_logic_supply_check, test_high_short_detector, test_low_short_detector, measure_high_drain_source;
  logic measure_low_drain_source, amp_supply_test, output_stage_enable, charge_pump_enable, short_detect_enable;
  logic bootstrap_uv_enable, feedback_enable, limp_reaction_active, ov_shutdown_enable, battery_error_flag;
  logic battery_warning_flag, battery_fets_off, a, m, lm;
  logic [7:0] select_driver_wdata, select_amplifier_wdata, selftest_select_driver, selftest_select_amplifier;
  logic [7:0] shutdown_error_register, external_error_register, d, dv, av;
  logic [2:0] current_sense_amplifier_enable, limp_bridge, low_side_control_input, high_side_control_input_n;
  logic [2:0] low_side_gated, high_side_gated_n, failure_register_enable, mk;
  logic [3:0] battery_overvoltage_level, battery_undervoltage_level;
  logic [1:0] battery_overvoltage_filter, battery_undervoltage_filter, battery_ov_reaction, battery_uv_reaction;
  logic [15:0] battery_sample, battery_voltage_result, errs;
  logic [6:0] g, drv_seen;
  logic [5:0] amp_gain_test;
  logic [4:0] react;
  int err_total, checks_done, bi;
  `define CHK(NM, EXP, GOT) begin checks_done++; if ((GOT) !== (EXP)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", NM, EXP, GOT); end end
  assign errs = {shutdown_error_register, external_error_register};
  assign react = {battery_warning_flag, battery_error_flag, battery_fets_off, output_stage_enable, charge_pump_enable};
  assign drv_seen = {2'h0, test_logic_supply_check, test_high_short_detector, test_low_short_detector,
                     measure_high_drain_source, measure_low_drain_source};
  stl_supervisor #(.FILT0_CYC(F[0]), .FILT1_CYC(F[1]), .FILT2_CYC(F[2]), .FILT3_CYC(F[3])) i_dut (.*);
  stl_host_model i_host (.*);
  function automatic logic [6:0] msb(input logic [6:0] v);
    msb = 7'h00;
    for (int i = 0; i < 7; i++) if (v[i]) msb = 7'h01 << i;
  endfunction : msb
  // Warning, error and FETs-off per reaction code; a shutdown is always a latched error.
  function automatic logic [2:0] exp_react(input logic [1:0] r, input logic sd);
    exp_react = sd ? {r == 2'h0, 2'h3} : (r == 2'h0) ? 3'h4 : (r == 2'h1) ? 3'h2 : 3'h3;
  endfunction : exp_react
  task automatic summarize();
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Flag must stay clear through the filter time, then set, then clear once the host clears it.
  task automatic probe(input logic [15:0] v, input int b, input int f, input logic [1:0] r, input logic sd);
    i_host.pulse(1'b1, v);
    repeat (f - 1) @(posedge sys_clk);
    #1 `CHK("flag_early", 1'b0, errs[b])
    repeat (8) @(posedge sys_clk);
    #1 `CHK("flag_set", 1'b1, errs[b])
    `CHK("result", v, battery_voltage_result)
    `CHK("reaction", exp_react(r, sd), react[4:2])
    `CHK("fault_stage_pump", {~(sd | r[1]), ~sd}, react[1:0])
    i_host.pulse(1'b1, 16'h0500);
    repeat (3) @(posedge sys_clk);
    #1 `CHK("fets_hold", sd | (r == 2'h3), battery_fets_off)
    i_host.pulse(1'b0, 16'h0000);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("flag_clear", 16'h0000, errs)
    `CHK("react_clear", 5'h03, react)
  endtask : probe
  // ************************************************************
  // Clock, watchdog and test sequence
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  initial begin
    void'($urandom(32'h29baa8a5));
    {rst_n, err_total, checks_done, dv, av, low_side_control_input, high_side_control_input_n} = '0;
    {battery_overvoltage_level, battery_undervoltage_level} = {stl_pkg::OV_LEVEL_RESET, stl_pkg::UV_LEVEL_RESET};
    {battery_overvoltage_filter, battery_undervoltage_filter} = {stl_pkg::OV_FILTER_RESET, stl_pkg::UV_FILTER_RESET};
    {battery_ov_reaction, battery_uv_reaction, ov_shutdown_enable} = 5'h03;
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    i_host.pulse(1'b1, 16'h0500);
    i_host.pulse(1'b0, 16'h0000);
    for (int n = 0; n < 48; n++) begin
      d = (n < 16) ? 8'h01 << n[2:0] : 8'($urandom);
      a = (n < 16) ? n[3] : 1'($urandom);
      m = (n < 16) || (($urandom % 4) != 0);
      lm = 1'($urandom);
      bi = $urandom % 3;
      {low_side_control_input, high_side_control_input_n} = 6'($urandom);
      i_host.set_lvl(m, lm, bi);
      i_host.write_sel(a, d);
      {av, dv} = a ? {d, dv} : {av, d};
      @(posedge sys_clk);
      #1 g = m ? msb(av[6:0]) : 7'h00;
      mk = lm ? 3'h1 << bi : 3'h0;
      `CHK("drv_readback", dv & stl_pkg::DRV_VALID_MASK, selftest_select_driver)
      `CHK("amp_readback", av & stl_pkg::AMP_VALID_MASK, selftest_select_amplifier)
      `CHK("drv_tests", m ? msb({2'h0, dv[7:5], dv[2:1]}) : 7'h00, drv_seen)
      `CHK("amp_tests", g, {amp_gain_test, amp_supply_test})
      `CHK("csa_enable", ~{|g[6:5], |g[4:3], |g[2:1]}, current_sense_amplifier_enable)
      `CHK("stage_pump", 2'h3, {output_stage_enable, charge_pump_enable})
      `CHK("low_gated", low_side_control_input & ~mk, low_side_gated)
      `CHK("high_gated_n", high_side_control_input_n | mk, high_side_gated_n)
      `CHK("fail_enable", ~mk, failure_register_enable)
      `CHK("limp_ignore", {3{~lm}}, {short_detect_enable, bootstrap_uv_enable, feedback_enable})
      `CHK("limp_react", lm, limp_reaction_active)
    end
    for (int c = 0; c < 4; c++) begin
      {battery_undervoltage_filter, battery_overvoltage_filter} = {2'(c), 2'(c)};
      {battery_undervoltage_level, battery_overvoltage_level} = 8'($urandom);
      {battery_uv_reaction, battery_ov_reaction} = 4'($urandom);
      probe(stl_pkg::UV_TABLE[battery_undervoltage_level] - 16'h0001, 3, F[c],
            battery_uv_reaction, 1'b0);
      probe(stl_pkg::OV_TABLE[battery_overvoltage_level[3] ? 3'h7 : battery_overvoltage_level[2:0]] + 16'h0001,
            2, F[c], battery_ov_reaction, 1'b0);
      probe(stl_pkg::OV_SHUTDOWN_DEFAULT + 16'h0001, 14, F[c], battery_ov_reaction, 1'b1);
    end
    summarize();
  end
endmodule : test_stl_supervisor
